// File: hw/scd_device.sv
// Device end: SPI slave that decodes request words and answers them
`timescale 1ns/1ps
`include "scd_consts.svh"
// ----------------------------------------------------------------
// Overview of operation
// - 1880h enters configuration from default or error
// - 1140h enters verification from configuration only
// - 1220h leaves configuration to configured state
// - 1410h does nothing, still fully checked
// - Mode, nop and write commands answer status
// - Read word is address<<7, 002Ah, parity
// - Accepted read answers register bits 15..1, parity in bit 0
// - Active modes restrict read addresses, else error
// - Upper write loads buffer high byte only
// - Lower write carries address, data bits 7..2
// - Lower write commits buffer then clears it
// - Lower write outside allowed addresses is error
// - Odd parity bit 0; check optional, always generated
// - Unknown request word is an error
// - Answer comes in the following transfer
// - Error discards, sets flag, marks answer invalid
// ----------------------------------------------------------------
module scd_device import scd_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	scd_spi_if.dev           spi,
	input  wire logic        parity_check_enable,
	input  wire logic        err_clr,
	input  wire logic        mode_set_valid,
	input  wire scd_mode_t   mode_set,
	output      scd_mode_t   mode,
	output      logic        spi_error_flag,
	output      logic        reg_wr_stb,
	output      logic [4:0]  reg_wr_addr,
	output      logic [15:0] reg_wr_data
);
	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Counter that stops at its top value
	function automatic logic [4:0] sat_inc(input logic [4:0] v);
		return (v == 5'h1F) ? v : v + 5'h01;
	endfunction : sat_inc

	// Read permission per mode
	function automatic logic rd_allowed(input scd_mode_t m,
	                                    input logic [4:0] a);
		if (m == active_state || m == weak_active_state)
			return a <= `SCD_RUN_RD_LAST;
		return 1'b1;
	endfunction : rd_allowed

	// Write permission per mode; status is read-only
	function automatic logic wr_allowed(input scd_mode_t m,
	                                    input logic [4:0] a);
		if (a == `SCD_PST_ADDR)
			return 1'b0;
		if (m == configuration_state)
			return 1'b1;
		return a >= `SCD_RUN_WR_FIRST;
	endfunction : wr_allowed

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [2:0]  pin_lvl;          // Synced mosi, sclk, ncs_n
	logic [2:0]  pin_rise;         // Rising edges
	logic [2:0]  pin_fall;         // Falling edges
	logic        ncs_act;          // Chip select asserted
	logic        frame_start;      // Select just asserted
	logic        frame_end;        // Select just released
	logic        sck_rise;         // Clock rise inside frame
	logic        sck_fall;         // Clock fall inside frame
	logic [15:0] shin_r;           // Received word
	logic [15:0] shout_r;          // Word being sent
	logic [4:0]  rise_cnt_r;       // Rising edges this frame
	logic [4:0]  fall_cnt_r;       // Falling edges this frame
	logic        miso_r;           // Data pin
	logic        miso_oe_n_r;      // Pin enable, low drives
	scd_mode_t   mode_r;           // Current mode
	scd_mode_t   mode_nxt;         // Mode after this word
	logic        err_r;            // Sticky error flag
	logic [15:0] wbuf_r;           // Internal write buffer
	logic [15:0] rf_r [1:31];      // Register storage
	scd_ans_t    ans_kind_r;       // Answer for next transfer
	logic [4:0]  ans_addr_r;       // Register to answer
	logic [15:0] status;           // Primary status value
	logic [15:0] ans_body;         // Answer before parity
	logic [15:0] ans_word;         // Answer with parity
	logic [15:0] word;             // Word under decode
	logic [4:0]  addr;             // Address field
	logic        fmt_ok;           // Exactly one 16-bit word
	logic        par_ok;           // Parity passes or unchecked
	logic        cmd_err;          // Word refused
	logic        do_rd;            // Accepted read
	logic        do_wrh;           // Accepted upper write
	logic        do_wrl;           // Accepted lower write
	logic        wr_stb_r;         // Write strobe out
	logic [4:0]  wr_addr_r;        // Write address out
	logic [15:0] wr_data_r;        // Write data out

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	scd_sync #(.W(3), .INIT(3'b001)) u_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.din     ({spi.mosi, spi.sclk, spi.ncs_n}),
		.lvl     (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	assign ncs_act     = ~pin_lvl[0];
	assign frame_start = pin_fall[0];
	assign frame_end   = pin_rise[0];
	assign sck_rise    = pin_rise[1] & ncs_act;
	assign sck_fall    = pin_fall[1] & ncs_act;

	// ------------------------------------------------------------
	// Shift-out register and pin driver
	// ------------------------------------------------------------
	// Load the prepared answer at select, shift on clock rise
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			shout_r <= 16'h0000;
			miso_r  <= 1'b0;
		end else if (frame_start) begin
			shout_r <= ans_word;
			miso_r  <= 1'b0;
		end else if (sck_rise) begin
			miso_r  <= shout_r[15];
			shout_r <= {shout_r[14:0], 1'b0};
		end
	end

	// Drive the pin only while selected
	always_ff @(posedge mclk) begin
		if (sys_rst)
			miso_oe_n_r <= 1'b1;
		else if (frame_start)
			miso_oe_n_r <= 1'b0;
		else if (frame_end)
			miso_oe_n_r <= 1'b1;
	end

	assign spi.miso_o    = miso_r;
	assign spi.miso_oe_n = miso_oe_n_r;

	// ------------------------------------------------------------
	// Shift-in register and edge counters
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst)
			shin_r <= 16'h0000;
		else if (sck_fall)
			shin_r <= {shin_r[14:0], pin_lvl[2]};
	end

	// Count edges to check word format
	always_ff @(posedge mclk) begin
		if (sys_rst || frame_start) begin
			rise_cnt_r <= 5'h00;
			fall_cnt_r <= 5'h00;
		end else begin
			if (sck_rise)
				rise_cnt_r <= sat_inc(rise_cnt_r);
			if (sck_fall)
				fall_cnt_r <= sat_inc(fall_cnt_r);
		end
	end

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	assign word   = shin_r;
	assign addr   = word[`SCD_ADDR_LSB +: 5];
	assign fmt_ok = (rise_cnt_r == `SCD_WORD_BITS) &&
	                (fall_cnt_r == `SCD_WORD_BITS);
	assign par_ok = ~parity_check_enable | (^word);

	// Classify the word and decide acceptance
	always_comb begin
		cmd_err  = 1'b0;
		mode_nxt = mode_r;
		do_rd    = 1'b0;
		do_wrh   = 1'b0;
		do_wrl   = 1'b0;
		if (!fmt_ok) begin
			cmd_err = 1'b1;
		end else begin
			case (word)
				`SCD_CMD_ENTER_CFG: begin
					// Only from default or error
					if (mode_r == default_state || mode_r == error_state)
						mode_nxt = configuration_state;
					else
						cmd_err = 1'b1;
				end
				`SCD_CMD_ENTER_VER: begin
					if (mode_r == configuration_state)
						mode_nxt = verification_state;
					else
						cmd_err = 1'b1;
				end
				`SCD_CMD_LEAVE_CFG: begin
					if (mode_r == configuration_state)
						mode_nxt = configured_state;
					else
						cmd_err = 1'b1;
				end
				`SCD_CMD_NOP: begin
					// Checked by exact match, no action
					cmd_err = 1'b0;
				end
				default: begin
					if ((word & `SCD_RD_MASK) == `SCD_RD_PAT) begin
						if (par_ok && rd_allowed(mode_r, addr))
							do_rd = 1'b1;
						else
							cmd_err = 1'b1;
					end else if ((word & `SCD_WRH_MASK) == `SCD_WRH_PAT) begin
						if (par_ok)
							do_wrh = 1'b1;
						else
							cmd_err = 1'b1;
					end else if ((word & `SCD_WRL_MASK) == `SCD_WRL_PAT) begin
						if (par_ok && wr_allowed(mode_r, addr))
							do_wrl = 1'b1;
						else
							cmd_err = 1'b1;
					end else begin
						cmd_err = 1'b1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode, error flag and answer selection
	// ------------------------------------------------------------
	// Outside events take priority over commands
	always_ff @(posedge mclk) begin
		if (sys_rst)
			mode_r <= default_state;
		else if (mode_set_valid)
			mode_r <= mode_set;
		else if (frame_end)
			mode_r <= mode_nxt;
	end

	// Sticky error; a new error wins over a clear
	always_ff @(posedge mclk) begin
		if (sys_rst)
			err_r <= 1'b0;
		else if (frame_end && cmd_err)
			err_r <= 1'b1;
		else if (err_clr)
			err_r <= 1'b0;
	end

	// Remember what the next transfer returns
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ans_kind_r <= ANS_STATUS;
			ans_addr_r <= 5'h00;
		end else if (frame_end) begin
			if (cmd_err)
				ans_kind_r <= ANS_INVALID;
			else if (do_rd) begin
				ans_kind_r <= ANS_REG;
				ans_addr_r <= addr;
			end else
				ans_kind_r <= ANS_STATUS;
		end
	end

	// Build status and answer words
	always_comb begin
		status = `SCD_PST_RESET;
		status[`SCD_PST_MODE_POS +: 3] = mode_r;
		status[`SCD_PST_ERR_POS] = err_r;
		case (ans_kind_r)
			ANS_REG:
				ans_body = (ans_addr_r == `SCD_PST_ADDR) ? status
				           : rf_r[ans_addr_r];
			ANS_INVALID: begin
				ans_body = status;
				ans_body[`SCD_INVALID_POS] = 1'b1;
			end
			default:
				ans_body = status;
		endcase
		ans_word = {ans_body[15:1], ~^ans_body[15:1]};
	end

	// ------------------------------------------------------------
	// Write buffer and register storage
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst)
			wbuf_r <= `SCD_WBUF_RESET;
		else if (frame_end && do_wrl)
			wbuf_r <= `SCD_WBUF_RESET;
		else if (frame_end && do_wrh)
			wbuf_r[15:8] <= word[`SCD_DATA_LSB +: 8];
	end

	// Commit high byte with new low byte
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 1; i < 32; i++)
				rf_r[i] <= 16'h0000;
		end else if (frame_end && do_wrl) begin
			rf_r[addr] <= {wbuf_r[15:8], word[6:1], 2'b00};
		end
	end

	// Report each commit to the user side
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_stb_r  <= 1'b0;
			wr_addr_r <= 5'h00;
			wr_data_r <= 16'h0000;
		end else begin
			wr_stb_r <= frame_end && do_wrl;
			if (frame_end && do_wrl) begin
				wr_addr_r <= addr;
				wr_data_r <= {wbuf_r[15:8], word[6:1], 2'b00};
			end
		end
	end

	assign mode           = mode_r;
	assign spi_error_flag = err_r;
	assign reg_wr_stb     = wr_stb_r;
	assign reg_wr_addr    = wr_addr_r;
	assign reg_wr_data    = wr_data_r;
endmodule : scd_device

// File: hw/scd_consts.svh
// Constants of the SPI command decoder: commands, fields, timing
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH

// ----------------------------------------------------------------
// Fixed request words (parity already included)
// ----------------------------------------------------------------
`define SCD_CMD_ENTER_CFG  16'h1880
`define SCD_CMD_ENTER_VER  16'h1140
`define SCD_CMD_LEAVE_CFG  16'h1220
`define SCD_CMD_NOP        16'h1410

// ----------------------------------------------------------------
// Variable request words: mask and pattern
// ----------------------------------------------------------------
`define SCD_RD_MASK        16'hF07E
`define SCD_RD_PAT         16'h002A
`define SCD_WRH_MASK       16'hFE00
`define SCD_WRH_PAT        16'h4400
`define SCD_WRL_MASK       16'hF000
`define SCD_WRL_PAT        16'hA000
`define SCD_ADDR_LSB       7
`define SCD_DATA_LSB       1

// ----------------------------------------------------------------
// Primary status layout and address map
// ----------------------------------------------------------------
`define SCD_PST_ADDR       5'h00
`define SCD_PST_MODE_POS   0
`define SCD_PST_ERR_POS    4
`define SCD_INVALID_POS    15
`define SCD_PST_RESET      16'h0000
`define SCD_WBUF_RESET     16'h0000
`define SCD_RUN_RD_LAST    5'h0F
`define SCD_RUN_WR_FIRST   5'h18

// ----------------------------------------------------------------
// Word length and link timing
// ----------------------------------------------------------------
`define SCD_WORD_BITS      5'h10
`define SCD_MCLK_NS        10
`define SCD_SCLK_HALF_NS   80
`define SCD_SCLK_HALF_CYC  (`SCD_SCLK_HALF_NS / `SCD_MCLK_NS)
`define SCD_GAP_HALVES     3'h4

`endif

// File: hw/scd_pkg.sv
// Types shared by both ends of the SPI command decoder
package scd_pkg;

	// Operating modes of the device
	typedef enum logic [2:0] {
		default_state       = 3'b000,
		error_state         = 3'b001,
		configuration_state = 3'b010,
		configured_state    = 3'b011,
		active_state        = 3'b100,
		verification_state  = 3'b101,
		weak_active_state   = 3'b110
	} scd_mode_t;

	// Kind of answer prepared for the next transfer
	typedef enum logic [1:0] {
		ANS_STATUS  = 2'b00,
		ANS_INVALID = 2'b01,
		ANS_REG     = 2'b10
	} scd_ans_t;

	// Host sequencer states
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_LEAD = 3'b001,
		M_HIGH = 3'b010,
		M_LOW  = 3'b011,
		M_TAIL = 3'b100,
		M_GAP  = 3'b101
	} scd_mstate_t;

endpackage : scd_pkg

// File: hw/scd_spi_if.sv
// SPI link between the host end and the device end
`timescale 1ns/1ps
interface scd_spi_if;
	logic ncs_n;       // Chip select, low active
	logic sclk;        // Serial clock from host
	logic mosi;        // Request data
	logic miso_o;      // Answer data driven by device
	logic miso_oe_n;   // Device drives miso while low
	logic miso;        // Resolved answer wire

	// Released line shows the inverse, so a late sample stands out
	assign miso = miso_oe_n ? ~miso_o : miso_o;

	modport dev  (input ncs_n, input sclk, input mosi,
	              output miso_o, output miso_oe_n);
	modport host (output ncs_n, output sclk, output mosi, input miso);
endinterface : scd_spi_if

// File: hw/scd_sync.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module scd_sync #(
	parameter int unsigned   W    = 3,
	parameter logic [W-1:0]  INIT = '0
) (
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	input  wire logic [W-1:0]  din,
	output      logic [W-1:0]  lvl,
	output      logic [W-1:0]  rise,
	output      logic [W-1:0]  fall
);
	logic [W-1:0] s1_r;   // First stage, read by s2 only
	logic [W-1:0] s2_r;   // Settled level
	logic [W-1:0] s3_r;   // Previous level for edges

	// ------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Level and one-cycle edge pulses
	assign lvl  = s2_r;
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;
endmodule : scd_sync

// File: hw/scd_host.sv
// Host end: SPI master that sends one request word per transfer
`timescale 1ns/1ps
`include "scd_consts.svh"
module scd_host import scd_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	scd_spi_if.host          spi,
	input  wire logic        req_valid,
	input  wire logic [15:0] req_word,
	input  wire logic        req_bad_par,
	output      logic        req_ready,
	output      logic        ans_valid,
	output      logic [15:0] ans_word,
	output      logic        ans_par_err
);
	localparam logic [3:0] HALF_LAST = 4'(`SCD_SCLK_HALF_CYC - 1);

	scd_mstate_t state_r;      // Sequencer state
	logic [3:0]  div_r;        // Half-period divider
	logic        tick;         // One-cycle half-period enable
	logic [4:0]  bits_r;       // Bits exchanged
	logic [2:0]  gap_r;        // Halves spent idle after frame
	logic [15:0] txsh_r;       // Request shifter
	logic [15:0] rxsh_r;       // Answer shifter
	logic        ncs_n_r;      // Chip select pin
	logic        sclk_r;       // Clock pin
	logic        mosi_r;       // Data pin
	logic        ready_r;      // Request port ready
	logic        ans_v_r;      // Answer pulse
	logic [15:0] ans_r;        // Last answer
	logic        ans_pe_r;     // Answer parity wrong
	logic        miso_s;       // Synced answer bit

	// ------------------------------------------------------------
	// Answer pin synchroniser
	// ------------------------------------------------------------
	scd_sync #(.W(1), .INIT(1'b0)) u_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.din     (spi.miso),
		.lvl     (miso_s),
		.rise    (),
		.fall    ()
	);

	// ------------------------------------------------------------
	// Clock divider
	// ------------------------------------------------------------
	assign tick = (div_r == HALF_LAST);

	always_ff @(posedge mclk) begin
		if (sys_rst || state_r == M_IDLE || tick)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	end

	// ------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r  <= M_IDLE;
			ncs_n_r  <= 1'b1;
			sclk_r   <= 1'b0;
			mosi_r   <= 1'b0;
			ready_r  <= 1'b1;
			txsh_r   <= 16'h0000;
			rxsh_r   <= 16'h0000;
			bits_r   <= 5'h00;
			gap_r    <= 3'h0;
			ans_v_r  <= 1'b0;
			ans_r    <= 16'h0000;
			ans_pe_r <= 1'b0;
		end else begin
			ans_v_r <= 1'b0;
			case (state_r)
				M_IDLE: begin
					// Accept a word and insert odd parity
					if (req_valid && ready_r) begin
						txsh_r  <= {req_word[15:1],
						            (~^req_word[15:1]) ^ req_bad_par};
						ncs_n_r <= 1'b0;
						ready_r <= 1'b0;
						bits_r  <= 5'h00;
						state_r <= M_LEAD;
					end
				end
				M_LEAD, M_LOW: begin
					// Rise clock and present next bit
					if (tick) begin
						if (bits_r == `SCD_WORD_BITS)
							state_r <= M_TAIL;
						else begin
							sclk_r  <= 1'b1;
							mosi_r  <= txsh_r[15];
							txsh_r  <= {txsh_r[14:0], 1'b0};
							state_r <= M_HIGH;
						end
					end
				end
				M_HIGH: begin
					// Fall clock and capture answer bit
					if (tick) begin
						sclk_r  <= 1'b0;
						rxsh_r  <= {rxsh_r[14:0], miso_s};
						bits_r  <= bits_r + 5'h01;
						state_r <= M_LOW;
					end
				end
				M_TAIL: begin
					// Release select, hand answer out
					if (tick) begin
						ncs_n_r  <= 1'b1;
						mosi_r   <= 1'b0;
						ans_v_r  <= 1'b1;
						ans_r    <= rxsh_r;
						ans_pe_r <= ~(^rxsh_r);
						gap_r    <= 3'h0;
						state_r  <= M_GAP;
					end
				end
				M_GAP: begin
					// Give the device time to decode
					if (tick) begin
						if (gap_r == `SCD_GAP_HALVES - 3'h1) begin
							ready_r <= 1'b1;
							state_r <= M_IDLE;
						end else
							gap_r <= gap_r + 3'h1;
					end
				end
				default: state_r <= M_IDLE;
			endcase
		end
	end

	assign spi.ncs_n   = ncs_n_r;
	assign spi.sclk    = sclk_r;
	assign spi.mosi    = mosi_r;
	assign req_ready   = ready_r;
	assign ans_valid   = ans_v_r;
	assign ans_word    = ans_r;
	assign ans_par_err = ans_pe_r;
endmodule : scd_host

// File: bench/scd_link_checker.sv
// Protocol checker watching the SPI link between host and device
`timescale 1ns/1ps
module scd_link_checker (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ncs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe_n,
	input wire logic miso
);
	logic [4:0]  rise_cnt_r; // Clock rises in this frame
	logic [15:0] ans_sh_r;   // Answer bits taken at falls

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------
	// Helper logic
	// ------------------------------------------------
	// Rise counter, cleared between frames
	always_ff @(posedge mclk) begin
		if (sys_rst || ncs_n) begin
			rise_cnt_r <= 5'h00;
		end else if ($rose(sclk)) begin
			rise_cnt_r <= rise_cnt_r + 5'h01;
		end
	end
	// Answer shifter, sampled like the host does
	always_ff @(posedge mclk) begin
		if ($fell(sclk) && !ncs_n) begin
			ans_sh_r <= {ans_sh_r[14:0], miso};
		end
	end

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	property p_idle; ncs_n |-> !sclk; endproperty
	property p_oe_off; ncs_n [*5] |-> miso_oe_n; endproperty
	property p_oe_on; (!ncs_n) [*5] |-> !miso_oe_n; endproperty
	property p_lead;
		$fell(ncs_n) |-> (!sclk) [*7] ##[1:2] sclk;
	endproperty
	property p_high; $rose(sclk) |=> sclk [*7] ##1 !sclk; endproperty
	property p_low;
		$fell(sclk) && !ncs_n |=> (!sclk) [*7];
	endproperty
	property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
	property p_miso;
		$fell(sclk) && !ncs_n |-> $stable(miso_o);
	endproperty
	property p_count; $rose(ncs_n) |-> rise_cnt_r == 5'h10; endproperty
	property p_par; $rose(ncs_n) |-> ^ans_sh_r; endproperty

	a_idle: assert property (p_idle) else $error("sclk not idle");
	a_oe_off: assert property (p_oe_off) else $error("miso held");
	a_oe_on: assert property (p_oe_on) else $error("miso undriven");
	a_lead: assert property (p_lead) else $error("bad lead time");
	a_high: assert property (p_high) else $error("bad high time");
	a_low: assert property (p_low) else $error("bad low time");
	a_mosi: assert property (p_mosi) else $error("mosi moved");
	a_miso: assert property (p_miso) else $error("miso moved");
	a_count: assert property (p_count) else $error("edge count");
	a_par: assert property (p_par) else $error("answer parity");

	c_frame: cover property ($rose(ncs_n));
	c_drive: cover property ($fell(miso_oe_n));
	c_bit: cover property ($rose(sclk) && miso);
endmodule : scd_link_checker

// File: bench/spi_command_decoder_bench.sv
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module spi_command_decoder_bench import scd_pkg::*;;
	logic        mclk, sys_rst;       // Clock and reset
	logic        rq_v, rq_bad, rq_rdy; // Host request side
	logic [15:0] rq_w, an_w;          // Request and answer words
	logic        an_v, an_perr;       // Answer strobe, parity fault
	logic        par_en, err_clr;     // Device controls
	logic        ms_v;                // Outside mode load
	scd_mode_t   ms, mode;            // Mode to load, current mode
	logic        err_f, stb;          // Error flag, commit strobe
	logic [4:0]  wa, wa_r;            // Commit address, captured
	logic [15:0] wd, wd_r;            // Commit data, captured
	int          wr_cnt, failures, total_checks;

	scd_spi_if link ();

	scd_host i_scd_host (.mclk(mclk), .sys_rst(sys_rst), .spi(link),
		.req_valid(rq_v), .req_word(rq_w), .req_bad_par(rq_bad),
		.req_ready(rq_rdy), .ans_valid(an_v), .ans_word(an_w),
		.ans_par_err(an_perr));
	scd_device i_scd_device (.mclk(mclk), .sys_rst(sys_rst), .spi(link),
		.parity_check_enable(par_en), .err_clr(err_clr),
		.mode_set_valid(ms_v), .mode_set(ms), .mode(mode),
		.spi_error_flag(err_f), .reg_wr_stb(stb), .reg_wr_addr(wa),
		.reg_wr_data(wd));
	scd_link_checker i_scd_link_checker (.mclk(mclk), .sys_rst(sys_rst),
		.ncs_n(link.ncs_n), .sclk(link.sclk), .mosi(link.mosi),
		.miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n),
		.miso(link.miso));

	// ------------------------------------------------
	// Clock, commit capture, watchdog
	// ------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Remember each committed write
	always @(posedge mclk) begin
		if (stb === 1'b1) begin
			wr_cnt++;
			wa_r <= wa;
			wd_r <= wd;
		end
	end
	// Cuts a hang short
	initial begin
		#200000;
		failures++;
		wrap_up();
	end

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	// Compare and count
	task automatic chk(input string nm, input logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask : chk
	// Status word as answered; bit 0 carries parity, so left zero
	function automatic logic [15:0] st(input logic l, e,
		input logic [2:0] m);
		return {l, 10'h000, e, 1'b0, m[2:1], 1'b0};
	endfunction : st
	// One transfer; checks the answer to the previous request
	task automatic tx(input logic [15:0] w, input logic bad,
		input logic [15:0] exp);
		int n;
		@(negedge mclk);
		rq_w = w;
		rq_bad = bad;
		rq_v = 1'b1;
		@(negedge mclk);
		rq_v = 1'b0;
		for (n = 0; n < 400 && an_v !== 1'b1; n++) @(negedge mclk);
		chk("ans_valid", {15'h0000, an_v}, 16'h0001);
		chk("answer", {an_w[15:1], 1'b0}, exp);
		chk("parity", {15'h0000, ^an_w, an_perr}, 16'h0002);
		for (n = 0; n < 100 && rq_rdy !== 1'b1; n++) @(negedge mclk);
	endtask : tx
	// Mode and error flag after a transfer
	task automatic cm(input logic [2:0] m, input logic e);
		chk("mode_flag", {12'h000, mode, err_f}, {12'h000, m, e});
	endtask : cm
	// Outside mode load pulse
	task automatic setm(input scd_mode_t m);
		@(negedge mclk);
		ms = m;
		ms_v = 1'b1;
		@(negedge mclk);
		ms_v = 1'b0;
	endtask : setm
	// Verdict and end of run
	task automatic wrap_up();
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// ------------------------------------------------
	// Test sequence
	// ------------------------------------------------
	initial begin
		{rq_v, rq_bad, err_clr, ms_v} = 4'h0;
		rq_w = 16'h0000;
		par_en = 1'b1;
		ms = default_state;
		{wr_cnt, failures, total_checks} = '0;
		sys_rst = 1'b1;
		repeat (20) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (5) @(negedge mclk);
		tx(16'h1410, 1'b0, st(0, 0, 0));
		tx(16'h1140, 1'b0, st(0, 0, 0));
		cm(3'h0, 1'b1);
		tx(16'h1880, 1'b0, st(1, 1, 0));
		cm(3'h2, 1'b1);
		tx(16'h454A, 1'b0, st(0, 1, 2));
		tx(16'hA2D6, 1'b0, st(0, 1, 2));
		chk("commit", {wa_r, wd_r[10:0]}, {5'h05, 11'h5AC});
		chk("high", wd_r, 16'hA5AC);
		tx(16'h02AA, 1'b0, st(0, 1, 2));
		tx(16'hA37E, 1'b0, 16'hA5AC);
		chk("cleared", wd_r, 16'h00FC);
		tx(16'h032A, 1'b0, st(0, 1, 2));
		@(negedge mclk);
		err_clr = 1'b1;
		@(negedge mclk);
		err_clr = 1'b0;
		cm(3'h2, 1'b0);
		tx(16'h1220, 1'b0, 16'h00FC);
		cm(3'h3, 1'b0);
		tx(16'hA2D6, 1'b0, st(0, 0, 3));
		chk("writes", wr_cnt[15:0], 16'h0002);
		tx(16'h1220, 1'b0, st(1, 1, 3));
		tx(16'h002A, 1'b1, st(1, 1, 3));
		par_en = 1'b0;
		tx(16'h002A, 1'b1, st(1, 1, 3));
		setm(active_state);
		tx(16'h082A, 1'b0, st(0, 1, 4));
		tx(16'h07AA, 1'b0, st(1, 1, 4));
		tx(16'h1410, 1'b1, 16'h0000);
		tx(16'h0000, 1'b0, st(1, 1, 4));
		setm(error_state);
		tx(16'h1880, 1'b0, st(1, 1, 1));
		cm(3'h2, 1'b1);
		tx(16'h1410, 1'b0, st(0, 1, 2));
		tx(16'h1140, 1'b0, st(0, 1, 2));
		cm(3'h5, 1'b1);
		setm(weak_active_state);
		tx(16'h082A, 1'b0, st(0, 1, 6));
		tx(16'h1410, 1'b0, st(1, 1, 6));
		wrap_up();
	end
endmodule : spi_command_decoder_bench
